// >>> verilog/eepc_params.svh
// Offsets, field positions, reset values and timing counts of the program/erase controller.
// Assumes a byte-wide register port and a 100 MHz MCLK.
`ifndef EEPC_PARAMS_SVH
`define EEPC_PARAMS_SVH
`define EEPC_ARRAY_BASE      16'h0800
`define EEPC_ARRAY_LAST      16'h09FF
`define EEPC_CTRL_ADDR       16'h0010
`define EEPC_ACR_ADDR        16'h0011
`define EEPC_NVR_ADDR        16'hFE1C
`define EEPC_SEC_LO          16'h08F0
`define EEPC_SEC_HI          16'h08FF
`define EEPC_BIT_SPARE       7
`define EEPC_BIT_OFF         6
`define EEPC_BIT_RAS1        5
`define EEPC_BIT_RAS0        4
`define EEPC_BIT_LAT         3
`define EEPC_BIT_AUTO        2
`define EEPC_BIT_PGM         0
`define EEPC_BIT_PRTCT       4
`define EEPC_CTRL_RESET      8'h00
`define EEPC_NVR_DEFAULT     8'hF0
`define EEPC_ERASED_BYTE     8'hFF
`define EEPC_TIMEBASE_NS     35000
`define EEPC_CLK_NS          10
`define EEPC_TIMEBASE_CYC    (`EEPC_TIMEBASE_NS / `EEPC_CLK_NS)
`define EEPC_AUTO_TICKS      16'h0064
`endif

// >>> verilog/eepc_pkg.sv
// Types shared by the program/erase controller.
// Assumes the constants header is included by the users of these types.
package eepc_pkg;
  typedef enum logic [1:0] {
    EEPC_BYTE_PROG,
    EEPC_BYTE_ERASE,
    EEPC_BLOCK_ERASE,
    EEPC_BULK_ERASE
  } eepc_mode_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } eepc_bus_s;

  typedef enum logic [1:0] {
    EEPC_IDLE,
    EEPC_LATCHING,
    EEPC_HV_ON
  } eepc_state_e;

  typedef struct packed {
    eepc_state_e state;
    logic [7:0]  ctrl;
    logic [7:0]  acr;
    logic [7:0]  nvr;
    logic        valid;
    logic [8:0]  lat_addr;
    logic [7:0]  lat_data;
    logic [7:0]  rdata;
    logic [15:0] tb_cnt;
    logic [15:0] tick_cnt;
    logic        failed;
    logic        acr_loaded;
  } eepc_state_s;
endpackage

// >>> verilog/eepc_ctrl.sv
// Program/erase controller for a 512-byte on-chip EEPROM array with its control register.
// Assumes a CPU bus port with one-cycle strobes and read data in the following cycle.
//
// Operation
// - Self-timed option runs a timer that ends the cycle and clears high_voltage_enable.
// - Program only clears bits, erase only sets them; unprotected bytes only, the config byte is never written.
// - Mode field picks byte program, byte, block or bulk erase; reset clears it.
// - While capturing with the pump off, in-array bus writes load address and data.
// - While capturing, control writes are blocked until a valid array write.
// - The most recent captured array write replaces earlier ones.
// - Array reads while capturing return latched data and capture the read address.
// - Setting high voltage is ignored without capture bit or a valid capture.
// - Valid high voltage set turns on the pump; reset clears it.
// - Capture bit stays set while high voltage is on; a joint clear drops only high voltage.
// - Power-down bit blocks array updates but not array reads; reset clears it.
// - Control bit 7 is plain storage with no effect.
// - Capture bit is reset-cleared and switches the buses to capture mode.
// - The configuration shadow is read-only and reloaded from the config byte at reset.
// - Four 128-byte blocks, each guarded by its own protect bit.
// - Security lock refuses block and bulk erase; byte operations stay on unprotected bytes outside 08F0-08FF.
// - Timing counts run on a 35 us timebase.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "eepc_params.svh"

module eepc_ctrl (
  input  wire logic             MCLK,
  input  wire logic             RESET,
  input  wire eepc_pkg::eepc_bus_s BUS,
  output logic [7:0]            RDATA,
  output logic                  CHARGE_PUMP_ON,
  output logic                  ARRAY_POWER_DOWN,
  output logic                  OP_FAILED
);
  import eepc_pkg::*;

  eepc_state_s r;
  eepc_state_s n;
  logic [7:0]  mem [0:511];
  logic [8:0]  bus_idx;
  logic        in_array;
  logic        is_nvr;
  logic        allowed;
  logic        done;
  logic [7:0]  cw;
  logic        write_go;
  logic [7:0]  cur;
  logic [7:0]  newb;

  function automatic logic prot_block(input logic [7:0] acr, input logic [8:0] idx);
    prot_block = acr[idx[8:7]];
  endfunction

  function automatic logic secured(input logic [8:0] idx);
    secured = ({7'h00, idx} + `EEPC_ARRAY_BASE) >= `EEPC_SEC_LO &&
              ({7'h00, idx} + `EEPC_ARRAY_BASE) <= `EEPC_SEC_HI;
  endfunction

  assign bus_idx  = BUS.addr[8:0] - 9'h000;
  assign in_array = BUS.addr >= `EEPC_ARRAY_BASE && BUS.addr <= `EEPC_ARRAY_LAST;
  assign is_nvr   = BUS.addr == `EEPC_NVR_ADDR;
  assign done     = r.tick_cnt == `EEPC_AUTO_TICKS;
  assign cw       = BUS.wdata;
  assign cur      = r.lat_addr[8:0] == 9'h000 ? mem[9'h000] : mem[r.lat_addr];

  // Lock closes block and bulk erase entirely; protect bits close their blocks.
  always_comb begin
    logic lock;
    lock    = ~r.acr[`EEPC_BIT_PRTCT];
    allowed = 1'b1;
    if (prot_block(r.acr, r.lat_addr)) begin
      allowed = 1'b0;
    end
    if (lock && secured(r.lat_addr)) begin
      allowed = 1'b0;
    end
    if (lock && r.ctrl[`EEPC_BIT_RAS1]) begin
      allowed = 1'b0;
    end
  end

  assign write_go = r.state == EEPC_HV_ON &&
                    (done && r.ctrl[`EEPC_BIT_AUTO] ||
                     BUS.wr && BUS.addr == `EEPC_CTRL_ADDR && !cw[`EEPC_BIT_PGM]);
  assign newb = r.ctrl[`EEPC_BIT_RAS0] | r.ctrl[`EEPC_BIT_RAS1] ?
                `EEPC_ERASED_BYTE : cur & r.lat_data;

  always_comb begin
    n = r;
    n.rdata = 8'h00;
    if (!r.acr_loaded) begin
      n.acr        = r.nvr;
      n.acr_loaded = 1'b1;
    end
    if (r.state == EEPC_HV_ON) begin
      n.tb_cnt = r.tb_cnt + 16'h0001;
      if (r.tb_cnt == 16'(`EEPC_TIMEBASE_CYC - 1)) begin
        n.tb_cnt   = 16'h0000;
        n.tick_cnt = r.tick_cnt + 16'h0001;
      end
    end
    if (BUS.rd) begin
      if (BUS.addr == `EEPC_CTRL_ADDR) begin
        n.rdata = r.ctrl;
      end else if (BUS.addr == `EEPC_ACR_ADDR) begin
        n.rdata = r.acr;
      end else if (is_nvr) begin
        n.rdata = r.nvr;
      end else if (in_array && r.ctrl[`EEPC_BIT_LAT]) begin
        n.rdata    = r.lat_data;
        n.lat_addr = bus_idx;
        if (r.state == EEPC_HV_ON) begin
          n.failed = 1'b1;
        end
      end else if (in_array) begin
        n.rdata = mem[bus_idx];
      end
    end
    if (BUS.wr && in_array && r.ctrl[`EEPC_BIT_LAT] && r.state != EEPC_HV_ON) begin
      n.lat_addr = bus_idx;
      n.lat_data = cw;
      n.valid    = 1'b1;
      n.state    = EEPC_LATCHING;
    end
    if (BUS.wr && BUS.addr == `EEPC_CTRL_ADDR) begin
      if (r.state == EEPC_HV_ON) begin
        if (!cw[`EEPC_BIT_PGM]) begin
          n.ctrl[`EEPC_BIT_PGM] = 1'b0;
          n.state               = EEPC_LATCHING;
        end
      end else if (!(r.ctrl[`EEPC_BIT_LAT] && !r.valid)) begin
        n.ctrl = cw;
        n.ctrl[1] = 1'b0;
        n.ctrl[`EEPC_BIT_PGM] = 1'b0;
        if (cw[`EEPC_BIT_PGM] && r.ctrl[`EEPC_BIT_LAT] && r.valid) begin
          n.ctrl[`EEPC_BIT_PGM] = 1'b1;
          n.ctrl[`EEPC_BIT_LAT] = 1'b1;
          n.state    = EEPC_HV_ON;
          n.tb_cnt   = 16'h0000;
          n.tick_cnt = 16'h0000;
          n.failed   = 1'b0;
        end
        if (!cw[`EEPC_BIT_LAT]) begin
          n.valid = 1'b0;
          n.state = EEPC_IDLE;
        end
      end
    end
    if (r.state == EEPC_HV_ON && done && r.ctrl[`EEPC_BIT_AUTO]) begin
      n.ctrl[`EEPC_BIT_PGM] = 1'b0;
      n.state               = EEPC_LATCHING;
    end
  end

  // The array cell update is committed when the pump switches off, so an aborted pass leaves
  // the cell untouched if the read-during-pump fault flagged it, the byte is refused or the array is powered down.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      r       <= '0;
      r.nvr   <= `EEPC_NVR_DEFAULT;
    end else begin
      r <= n;
      if (write_go && allowed && !r.failed) begin
        if (r.lat_addr == 9'h000 && 1'b0) begin
          r.nvr <= newb;
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET && write_go && allowed && !r.failed && !r.ctrl[`EEPC_BIT_OFF]) begin
      unique case (eepc_mode_e'(r.ctrl[`EEPC_BIT_RAS1:`EEPC_BIT_RAS0]))
        EEPC_BYTE_PROG:   mem[r.lat_addr] <= newb;
        EEPC_BYTE_ERASE:  mem[r.lat_addr] <= newb;
        EEPC_BLOCK_ERASE: for (int i = 0; i < 128; i++) begin
          if (!prot_block(r.acr, r.lat_addr)) begin
            mem[{r.lat_addr[8:7], 7'(i)}] <= `EEPC_ERASED_BYTE;
          end
        end
        EEPC_BULK_ERASE:  for (int i = 0; i < 512; i++) begin
          if (!prot_block(r.acr, 9'(i))) begin
            mem[i] <= `EEPC_ERASED_BYTE;
          end
        end
      endcase
    end
  end

  assign RDATA            = r.rdata;
  assign CHARGE_PUMP_ON   = r.state == EEPC_HV_ON;
  assign ARRAY_POWER_DOWN = r.ctrl[`EEPC_BIT_OFF];
  assign OP_FAILED        = r.failed;

  AST_LAT_HOLD: assert property (@(posedge MCLK) disable iff (RESET)
    r.ctrl[`EEPC_BIT_PGM] |=> r.ctrl[`EEPC_BIT_LAT])
    else $error("Capture bit dropped while high voltage on.");
  AST_PGM_GUARD: assert property (@(posedge MCLK) disable iff (RESET)
    $rose(r.ctrl[`EEPC_BIT_PGM]) |-> $past(r.valid) && $past(r.ctrl[`EEPC_BIT_LAT]))
    else $error("High voltage set without valid capture.");
  AST_AUTO_END: assert property (@(posedge MCLK) disable iff (RESET)
    r.state == EEPC_HV_ON && r.ctrl[`EEPC_BIT_AUTO] && done |=> !r.ctrl[`EEPC_BIT_PGM])
    else $error("Self-timed cycle did not end.");
  AST_BLOCK: assert property (@(posedge MCLK) disable iff (RESET)
    BUS.wr && BUS.addr == `EEPC_CTRL_ADDR && r.ctrl[`EEPC_BIT_LAT] && !r.valid
    |=> r.ctrl == $past(r.ctrl))
    else $error("Control write not blocked before capture.");
  AST_CAPTURE: assert property (@(posedge MCLK) disable iff (RESET)
    BUS.wr && in_array && r.ctrl[`EEPC_BIT_LAT] && r.state != EEPC_HV_ON
    |=> r.lat_data == $past(BUS.wdata) && r.valid)
    else $error("Array write not captured.");
  AST_LAT_READ: assert property (@(posedge MCLK) disable iff (RESET)
    BUS.rd && in_array && r.ctrl[`EEPC_BIT_LAT] |=> RDATA == $past(r.lat_data))
    else $error("Latched data not returned.");
  AST_PUMP: assert property (@(posedge MCLK) disable iff (RESET)
    CHARGE_PUMP_ON == r.ctrl[`EEPC_BIT_PGM])
    else $error("Pump state and enable bit disagree.");
  AST_SHADOW: assert property (@(posedge MCLK) disable iff (RESET)
    r.acr_loaded |=> r.acr == $past(r.acr))
    else $error("Configuration shadow changed after load.");
endmodule

// >>> dv/eepc_cpu_model.sv
// CPU bus master model that drives the controller's byte-wide register and array port.
// Assumes the bench calls its tasks one at a time, from a single process.
`timescale 1ns/10ps

module eepc_cpu_model (
  input  wire logic           mclk,
  input  wire logic [7:0]     rdata,
  output eepc_pkg::eepc_bus_s bus
);
  import eepc_pkg::*;

  initial begin
    bus = '0;
  end

  // Released address and data show the inverse of their last value, so that the
  // design cannot rely on stale bus contents.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask
endmodule

// >>> dv/eepc_ctrl_test.sv
// Self-checking bench for the program/erase controller.
// Assumes the constants header and the package are compiled ahead of this file.
`timescale 1ns/10ps
`include "eepc_params.svh"

module eepc_ctrl_test;
  import eepc_pkg::*;
  logic       MCLK;
  logic       RESET;
  eepc_bus_s  BUS;
  logic [7:0] RDATA;
  logic       CHARGE_PUMP_ON;
  logic       ARRAY_POWER_DOWN;
  logic       OP_FAILED;
  logic [7:0] got;
  int         mismatches;
  int         compares;

  eepc_ctrl dut (
    .MCLK            (MCLK),
    .RESET           (RESET),
    .BUS             (BUS),
    .RDATA           (RDATA),
    .CHARGE_PUMP_ON  (CHARGE_PUMP_ON),
    .ARRAY_POWER_DOWN(ARRAY_POWER_DOWN),
    .OP_FAILED       (OP_FAILED)
  );

  eepc_cpu_model cpu (
    .mclk (MCLK),
    .rdata(RDATA),
    .bus  (BUS)
  );

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    cpu.rd(a, got);
    check(got, e, "read data");
  endtask

  // Outputs packed as {fail, power down, pump}, looked at once a write has landed.
  task automatic ochk(input logic [7:0] e);
    repeat (2) @(posedge MCLK);
    #1;
    check({5'h00, OP_FAILED, ARRAY_POWER_DOWN, CHARGE_PUMP_ON}, e, "outputs");
  endtask

  // One manual program or erase pass: arm, capture, pump on, pump off, release capture.
  task automatic pe(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    cpu.wr(`EEPC_CTRL_ADDR, c);
    cpu.wr(a, d);
    cpu.wr(`EEPC_CTRL_ADDR, c | 8'h01);
    cpu.wr(`EEPC_CTRL_ADDR, c);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h00);
  endtask

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    RESET = 1'b1;
    repeat (10) @(posedge MCLK);
    RESET <= 1'b0;
    repeat (2) @(posedge MCLK);
    ochk(8'h00);
    rchk(`EEPC_CTRL_ADDR, `EEPC_CTRL_RESET);
    rchk(`EEPC_ACR_ADDR, `EEPC_NVR_DEFAULT);
    cpu.wr(`EEPC_ACR_ADDR, 8'h00);
    rchk(`EEPC_ACR_ADDR, `EEPC_NVR_DEFAULT);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h80);
    rchk(`EEPC_CTRL_ADDR, 8'h80);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h40);
    ochk(8'h02);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h01);
    rchk(`EEPC_CTRL_ADDR, 8'h00);
    ochk(8'h00);
    // Capture armed with nothing valid captured: control stays locked.
    cpu.wr(`EEPC_CTRL_ADDR, 8'h08);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h09);
    cpu.wr(16'h0A00, 8'h55);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h09);
    rchk(`EEPC_CTRL_ADDR, 8'h08);
    cpu.wr(16'h0800, 8'h12);
    cpu.wr(16'h0801, 8'h34);
    rchk(16'h0801, 8'h34);
    rchk(16'h0800, 8'h34);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h09);
    rchk(`EEPC_CTRL_ADDR, 8'h09);
    ochk(8'h01);
    cpu.rd(16'h0800, got);
    ochk(8'h05);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h00);
    rchk(`EEPC_CTRL_ADDR, 8'h08);
    cpu.wr(`EEPC_CTRL_ADDR, 8'h00);
    rchk(`EEPC_CTRL_ADDR, 8'h00);
    // Each mode with a capture in an unprotected block; the field must read back.
    for (int m = 0; m < 4; m++) begin
      cpu.wr(`EEPC_CTRL_ADDR, {2'b00, m[1:0], 4'h8});
      cpu.wr(16'h0980, 8'hA5);
      rchk(`EEPC_CTRL_ADDR, {2'b00, m[1:0], 4'h8});
      cpu.wr(`EEPC_CTRL_ADDR, 8'h00);
    end
    rchk(`EEPC_CTRL_ADDR, 8'h00);
    // Erase, then program twice: programming may only clear bits.
    pe(8'h18, 16'h0810, 8'h00);
    pe(8'h08, 16'h0810, 8'hA5);
    rchk(16'h0810, 8'hA5);
    pe(8'h08, 16'h0810, 8'h0F);
    rchk(16'h0810, 8'h05);
    pe(8'h28, 16'h0830, 8'h00);
    rchk(16'h0810, `EEPC_ERASED_BYTE);
    // A second reset in mid-run clears the control register and reloads the shadow.
    cpu.wr(`EEPC_CTRL_ADDR, 8'hC8);
    @(posedge MCLK);
    RESET <= 1'b1;
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    repeat (2) @(posedge MCLK);
    rchk(`EEPC_CTRL_ADDR, `EEPC_CTRL_RESET);
    rchk(`EEPC_ACR_ADDR, `EEPC_NVR_DEFAULT);
    conclude();
  end
endmodule
